/* File: core/vtc_setup.sv */
// Purpose: Setup register and channel control of the voltage/temperature conversion channel.
// Assumes: The serial interface presents decoded pointer accesses, synchronous to i_clock.
// Notes:   Analog controls are frozen while a conversion runs, so a write lands on the next one.
//
// Summary of operation
// - Eight-bit setup at pointer 0x08, resets zero.
// - Bit 7 admits channel to conversions, calibrations.
// - Bits 6:5 choose one of four inputs.
// - Bit 4 set: external reference for voltage/supply.
// - Bit 4 clear: internal reference is used.
// - Bit 1 shorts input for offset test.
// - Bit 0 turns internal chopping on.
// - Results land in 0x04-0x06, frozen during reads.
module vtc_setup #(
    parameter int DATA_WIDTH = 24
) (
    input  wire logic                  i_clock,
    input  wire logic                  i_rst,
    // Register port from the serial interface.
    input  wire logic                  i_reg_write,
    input  wire logic                  i_reg_read,
    input  wire logic [7:0]            i_reg_pointer,
    input  wire logic [7:0]            i_reg_wdata,
    input  wire logic                  i_result_read_active,
    output logic      [7:0]            o_reg_rdata,
    // Conversion sequencing.
    input  wire logic                  i_conv_request,
    input  wire logic                  i_conv_done,
    input  wire logic [DATA_WIDTH-1:0] i_conv_data,
    output logic                       o_conv_go,
    output logic                       o_conv_busy,
    output logic                       o_data_ready,
    output logic                       o_result_lost,
    // Analog channel controls.
    output logic [vtc_pkg::INPUT_COUNT-1:0] o_input_onehot,
    output logic                       o_external_reference_select,
    output logic                       o_internal_reference_select,
    output logic                       o_input_short_test,
    output logic                       o_chopping_enable
);

    // Returns true when a pointer names the given register.
    function automatic logic ptr_is(input logic [7:0] ptr, input logic [7:0] target);
        ptr_is = (ptr == target);
    endfunction : ptr_is

    // Setup register and its fields.
    logic [7:0]  setup_r;                     // Stored setup byte.
    logic [7:0]  setup_nxt;                   // Setup byte after this cycle's write.
    wire         vt_channel_enable;           // Channel takes part in conversions.
    wire         input_select_high;           // Input select, upper bit.
    wire         input_select_low;            // Input select, lower bit.
    wire  [1:0]  input_select;                // Whole input select field.
    wire         external_reference_select;   // External reference requested.
    wire         input_short_test;            // Input short requested.
    wire         chopping_enable;             // Chopping requested.

    // Conversion tracking.
    vtc_pkg::vtc_conv_state_t state_r;        // Current conversion state.
    vtc_pkg::vtc_conv_state_t state_nxt;      // Next conversion state.
    wire         start_w;                     // A conversion of this channel begins.

    // Controls frozen for the running conversion.
    logic [vtc_pkg::INPUT_COUNT-1:0] onehot_r;  // Selected input, one-hot.
    logic [vtc_pkg::INPUT_COUNT-1:0] onehot_nxt;// Decoded input for the next start.
    logic        ext_ref_r;                   // External reference in use.
    wire         ext_ref_nxt;                 // External reference for the next start.
    logic        short_r;                     // Input short in use.
    logic        chop_r;                      // Chopping in use.

    // Result path and read side.
    wire  [DATA_WIDTH-1:0] result_w;          // Stored result.
    wire         captured_w;                  // Result stored this cycle.
    wire         lost_w;                      // Result dropped this cycle.
    logic        ready_r;                     // Unread result available.
    logic        go_r;                        // Start pulse to the modulator.
    logic [7:0]  rdata_r;                     // Registered read answer.
    logic [7:0]  rdata_nxt;                   // Read answer selected now.
    wire         wr_setup_w;                  // Write to the setup pointer.
    wire         rd_result_w;                 // Read of any result byte.

    // Field extraction from the stored setup byte.
    assign vt_channel_enable         = setup_r[vtc_pkg::BIT_CHANNEL_ENABLE];
    assign input_select_high         = setup_r[vtc_pkg::BIT_SELECT_HIGH];
    assign input_select_low          = setup_r[vtc_pkg::BIT_SELECT_LOW];
    assign input_select              = {input_select_high, input_select_low};
    assign external_reference_select = setup_r[vtc_pkg::BIT_EXT_REFERENCE];
    assign input_short_test          = setup_r[vtc_pkg::BIT_INPUT_SHORT];
    assign chopping_enable           = setup_r[vtc_pkg::BIT_CHOP_ENABLE];

    // Pointer decode for writes and result reads.
    assign wr_setup_w  = i_reg_write && ptr_is(i_reg_pointer, vtc_pkg::PTR_SETUP);
    assign rd_result_w = i_reg_read && (ptr_is(i_reg_pointer, vtc_pkg::PTR_RESULT_HI) ||
                                        ptr_is(i_reg_pointer, vtc_pkg::PTR_RESULT_MID) ||
                                        ptr_is(i_reg_pointer, vtc_pkg::PTR_RESULT_LO));

    // Unused bits are masked so they can never reach the analog side and always read zero.
    assign setup_nxt = wr_setup_w ? (i_reg_wdata & vtc_pkg::SETUP_WRITE_MASK) : setup_r;

    // Setup register storage.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            setup_r <= vtc_pkg::SETUP_RESET;
        end else begin
            setup_r <= setup_nxt;
        end
    end

    // One-hot decode of the input select field, one line per input.
    genvar gi;
    generate
        for (gi = 0; gi < vtc_pkg::INPUT_COUNT; gi++) begin : g_input_decode
            assign onehot_nxt[gi] = (input_select == 2'(gi));
        end
    endgenerate

    // The external reference only serves the voltage input and the supply monitor.
    // Sensor inputs stay on the internal reference; the host must not ask otherwise.
    assign ext_ref_nxt = external_reference_select &&
                         ((input_select == vtc_pkg::INPUT_EXT_VOLT) ||
                          (input_select == vtc_pkg::INPUT_SUPPLY));

    // A disabled channel ignores single, continuous and calibration requests alike.
    assign start_w = i_conv_request && vt_channel_enable && (state_r == vtc_pkg::CONV_IDLE);

    // Next-state logic of the conversion tracker.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            vtc_pkg::CONV_IDLE: begin
                // Wait for an admitted request.
                if (start_w) begin
                    state_nxt = vtc_pkg::CONV_BUSY;
                end
            end
            vtc_pkg::CONV_BUSY: begin
                // The modulator reports the end of the conversion.
                if (i_conv_done) begin
                    state_nxt = vtc_pkg::CONV_IDLE;
                end
            end
            default: begin
                // Recover from an illegal code.
                state_nxt = vtc_pkg::CONV_IDLE;
            end
        endcase
    end

    // Conversion state and the frozen analog controls.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_r   <= vtc_pkg::CONV_IDLE;
            go_r      <= 1'b0;
            onehot_r  <= vtc_pkg::INPUT_COUNT'(1'b1);
            ext_ref_r <= 1'b0;
            short_r   <= 1'b0;
            chop_r    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            go_r    <= start_w;
            // Controls change only at a start, so a write never disturbs a running conversion.
            if (start_w) begin
                onehot_r  <= onehot_nxt;
                ext_ref_r <= ext_ref_nxt;
                short_r   <= input_short_test;
                chop_r    <= chopping_enable;
            end
        end
    end

    // Result register for the channel, frozen while the host reads it.
    vtc_result_reg #(
        .DATA_WIDTH (DATA_WIDTH)
    ) u_result (
        .i_clock    (i_clock),
        .i_rst      (i_rst),
        .i_done     (i_conv_done && (state_r == vtc_pkg::CONV_BUSY)),
        .i_data     (i_conv_data),
        .i_hold     (i_result_read_active),
        .o_result   (result_w),
        .o_captured (captured_w),
        .o_lost     (lost_w)
    );

    // Read answer selection; unmapped pointers answer zero.
    always_comb begin
        rdata_nxt = vtc_pkg::READ_NONE;
        if (ptr_is(i_reg_pointer, vtc_pkg::PTR_RESULT_HI)) begin
            rdata_nxt = result_w[DATA_WIDTH-1 -: 8];
        end else if (ptr_is(i_reg_pointer, vtc_pkg::PTR_RESULT_MID)) begin
            rdata_nxt = result_w[DATA_WIDTH-9 -: 8];
        end else if (ptr_is(i_reg_pointer, vtc_pkg::PTR_RESULT_LO)) begin
            rdata_nxt = result_w[DATA_WIDTH-17 -: 8];
        end else if (ptr_is(i_reg_pointer, vtc_pkg::PTR_SETUP)) begin
            rdata_nxt = setup_r;
        end
    end

    // Read data register and the unread-data flag; a new result beats a clearing read.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rdata_r <= vtc_pkg::READ_NONE;
            ready_r <= 1'b0;
        end else begin
            if (i_reg_read) begin
                rdata_r <= rdata_nxt;
            end
            if (captured_w) begin
                ready_r <= 1'b1;
            end else if (rd_result_w) begin
                ready_r <= 1'b0;
            end
        end
    end

    // Output drive.
    assign o_reg_rdata                 = rdata_r;
    assign o_conv_go                   = go_r;
    assign o_conv_busy                 = (state_r == vtc_pkg::CONV_BUSY);
    assign o_data_ready                = ready_r;
    assign o_result_lost               = lost_w;
    assign o_input_onehot              = onehot_r;
    assign o_external_reference_select = ext_ref_r;
    assign o_internal_reference_select = !ext_ref_r;
    assign o_input_short_test          = short_r;
    assign o_chopping_enable           = chop_r;

endmodule : vtc_setup

/* File: inc/vtc_pkg.sv */
// Purpose: Shared constants for the voltage/temperature channel setup block.
// Assumes: Register pointers and data bytes are eight bits wide.
// Notes:   Every pointer, bit position and code, and the setup, result and read reset values, are named here.
package vtc_pkg;

    // Register pointers on the internal register port.
    localparam logic [7:0] PTR_RESULT_HI  = 8'h04;  // Result bits 23..16.
    localparam logic [7:0] PTR_RESULT_MID = 8'h05;  // Result bits 15..8.
    localparam logic [7:0] PTR_RESULT_LO  = 8'h06;  // Result bits 7..0.
    localparam logic [7:0] PTR_SETUP      = 8'h08;  // Channel setup register.

    // Reset values.
    localparam logic [7:0]  SETUP_RESET  = 8'h00;   // Setup register after reset.
    localparam logic [23:0] RESULT_RESET = 24'h000000; // Result register after reset.
    localparam logic [7:0]  READ_NONE    = 8'h00;   // Read answer for unmapped pointers.

    // Bit positions inside the setup register.
    localparam int BIT_CHANNEL_ENABLE = 7;  // Channel takes part in conversions.
    localparam int BIT_SELECT_HIGH    = 6;  // Input select, upper bit.
    localparam int BIT_SELECT_LOW     = 5;  // Input select, lower bit.
    localparam int BIT_EXT_REFERENCE  = 4;  // External reference select.
    localparam int BIT_INPUT_SHORT    = 1;  // Input short for offset test.
    localparam int BIT_CHOP_ENABLE    = 0;  // Internal chopping.

    // Writable bits; bits 3 and 2 are unused and always read as zero.
    localparam logic [7:0] SETUP_WRITE_MASK = 8'hf3;

    // Channel input codes of the two-bit select field.
    localparam logic [1:0] INPUT_INT_TEMP = 2'h0;   // Internal temperature sensor.
    localparam logic [1:0] INPUT_EXT_DIODE = 2'h1;  // External sensing diode.
    localparam logic [1:0] INPUT_SUPPLY   = 2'h2;   // Supply monitor.
    localparam logic [1:0] INPUT_EXT_VOLT = 2'h3;   // External voltage input.
    localparam int         INPUT_COUNT    = 4;      // Number of selectable inputs.

    // Conversion tracking states, one-hot.
    typedef enum logic [1:0] {
        CONV_IDLE = 2'b01,
        CONV_BUSY = 2'b10
    } vtc_conv_state_t;

endpackage : vtc_pkg

/* File: core/vtc_result_reg.sv */
// Purpose: Holds the latest finished conversion of the voltage/temperature channel.
// Assumes: i_hold is high for the whole serial read of the result, up to its stop condition.
// Notes:   A result that finishes while the register is held is dropped, never merged.
module vtc_result_reg #(
    parameter int DATA_WIDTH = 24
) (
    input  wire logic                  i_clock,
    input  wire logic                  i_rst,
    input  wire logic                  i_done,
    input  wire logic [DATA_WIDTH-1:0] i_data,
    input  wire logic                  i_hold,
    output logic      [DATA_WIDTH-1:0] o_result,
    output logic                       o_captured,
    output logic                       o_lost
);

    logic [DATA_WIDTH-1:0] result_r;     // Stored conversion result.
    logic                  captured_r;   // One-cycle pulse when a result is stored.
    logic                  lost_r;       // One-cycle pulse when a result is dropped.
    wire                   take_w;       // A finished result may be stored now.

    // Freezing during a read keeps the three bytes of one result together.
    assign take_w = i_done && !i_hold;

    // Storage and the two event pulses.
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            result_r   <= DATA_WIDTH'(vtc_pkg::RESULT_RESET);
            captured_r <= 1'b0;
            lost_r     <= 1'b0;
        end else begin
            if (take_w) begin
                result_r <= i_data;
            end
            captured_r <= take_w;
            lost_r     <= i_done && i_hold;
        end
    end

    assign o_result   = result_r;
    assign o_captured = captured_r;
    assign o_lost     = lost_r;

endmodule : vtc_result_reg

/* File: tb/vtc_setup_props.sv */
// Purpose: Port-level checks of the voltage/temperature channel setup block.
// Assumes: Inputs change away from the rising clock edge.
// Notes:   Setup contents are hidden here, so outputs are tied to inputs and to each other.
module vtc_setup_props (
    input wire logic                            i_clock,
    input wire logic                            i_rst,
    input wire logic                            i_reg_read,
    input wire logic [7:0]                      i_reg_pointer,
    input wire logic                            i_result_read_active,
    input wire logic                            i_conv_request,
    input wire logic                            i_conv_done,
    input wire logic [7:0]                      o_reg_rdata,
    input wire logic                            o_conv_go,
    input wire logic                            o_conv_busy,
    input wire logic                            o_data_ready,
    input wire logic                            o_result_lost,
    input wire logic [vtc_pkg::INPUT_COUNT-1:0] o_input_onehot,
    input wire logic                            o_external_reference_select,
    input wire logic                            o_internal_reference_select,
    input wire logic                            o_input_short_test,
    input wire logic                            o_chopping_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // Pointers that hold no register must read back as zero.
    wire unmapped = !(i_reg_pointer inside {8'h04, 8'h05, 8'h06, 8'h08});
    // A conversion finishing freely, or while the result is frozen by a read.
    sequence s_done_free; o_conv_busy && i_conv_done && !i_result_read_active; endsequence
    sequence s_done_held; o_conv_busy && i_conv_done && i_result_read_active; endsequence
    a_go_needs_request: assert property (o_conv_go |-> $past(i_conv_request) && !$past(o_conv_busy))
        else $error("conversion started without an accepted request");
    a_go_one_cycle: assert property (o_conv_go |-> o_conv_busy ##1 !o_conv_go)
        else $error("start pulse malformed");
    a_done_frees: assert property ((o_conv_busy && i_conv_done) |=> !o_conv_busy)
        else $error("busy outlived the finished conversion");
    // The capture pulse comes first and the ready flag follows it one cycle later.
    a_ready_sets: assert property (s_done_free |=> !o_result_lost ##1 o_data_ready)
        else $error("free result not flagged ready");
    a_lost_pulse: assert property (s_done_held |=> o_result_lost ##1 !o_result_lost)
        else $error("frozen result not reported lost");
    a_ref_pair: assert property (o_internal_reference_select == !o_external_reference_select)
        else $error("reference selects disagree");
    a_ext_ref_input: assert property (o_external_reference_select |-> o_input_onehot[2] || o_input_onehot[3])
        else $error("external reference with wrong input");
    a_input_onehot: assert property ($onehot(o_input_onehot))
        else $error("input select not one-hot");
    a_ctl_frozen: assert property (o_conv_busy && !o_conv_go |->
        $stable({o_input_onehot, o_external_reference_select, o_input_short_test, o_chopping_enable}))
        else $error("controls moved during a conversion");
    a_unmapped_zero: assert property (i_reg_read && unmapped |=> o_reg_rdata == vtc_pkg::READ_NONE)
        else $error("unmapped pointer read nonzero");
endmodule : vtc_setup_props

bind vtc_setup vtc_setup_props i_props (.i_clock(i_clock), .i_rst(i_rst), .i_reg_read(i_reg_read),
    .i_reg_pointer(i_reg_pointer), .i_result_read_active(i_result_read_active),
    .i_conv_request(i_conv_request), .i_conv_done(i_conv_done), .o_reg_rdata(o_reg_rdata),
    .o_conv_go(o_conv_go), .o_conv_busy(o_conv_busy), .o_data_ready(o_data_ready),
    .o_result_lost(o_result_lost), .o_input_onehot(o_input_onehot),
    .o_external_reference_select(o_external_reference_select),
    .o_internal_reference_select(o_internal_reference_select),
    .o_input_short_test(o_input_short_test), .o_chopping_enable(o_chopping_enable));

/* File: tb/testbench.sv */
// Purpose: Self-checking bench of the channel setup block.
// Assumes: Inputs are driven on the falling clock edge.
// Notes:   Drivers queue expected read answers and controls; a monitor pops them at each read and each conversion start.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clock = 1'b0, i_rst = 1'b1, i_reg_write = 1'b0, i_reg_read = 1'b0;
    logic        i_result_read_active = 1'b0, i_conv_request = 1'b0, i_conv_done = 1'b0;
    logic [7:0]  i_reg_pointer = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata, s, rd_exp;
    logic [23:0] i_conv_data = 24'h000000, res;
    logic        o_conv_go, o_conv_busy, o_data_ready, o_result_lost, o_ext, o_int, o_short, o_chop, mon_rd;
    logic [3:0]  o_input_onehot;
    logic [6:0]  ctl_exp;
    logic [7:0]  rd_q[$];  // Expected read answers, oldest first.
    logic [6:0]  ctl_q[$]; // Expected controls at each conversion start.
    int          n_mismatch = 0, num_checks = 0;
    integer      seed = 32'h8bdc;
    // Free-running 20 MHz clock.
    always #25 i_clock = ~i_clock;
    vtc_setup #(.DATA_WIDTH(24)) i_vtc_setup (.i_clock(i_clock), .i_rst(i_rst), .i_reg_write(i_reg_write),
        .i_reg_read(i_reg_read), .i_reg_pointer(i_reg_pointer), .i_reg_wdata(i_reg_wdata),
        .i_result_read_active(i_result_read_active), .o_reg_rdata(o_reg_rdata),
        .i_conv_request(i_conv_request), .i_conv_done(i_conv_done), .i_conv_data(i_conv_data),
        .o_conv_go(o_conv_go), .o_conv_busy(o_conv_busy), .o_data_ready(o_data_ready),
        .o_result_lost(o_result_lost), .o_input_onehot(o_input_onehot),
        .o_external_reference_select(o_ext), .o_internal_reference_select(o_int),
        .o_input_short_test(o_short), .o_chopping_enable(o_chop));
    // Counts one comparison and reports a mismatch at once.
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cmp_rd(input logic [7:0] e);
        chk("read data", 24'(e), 24'(o_reg_rdata));
    endtask : cmp_rd
    task automatic cmp_ctl(input logic [6:0] e);
        chk("controls", 24'(e), 24'({o_input_onehot, o_ext, o_short, o_chop}));
        chk("internal reference", 24'(!e[2]), 24'(o_int));
    endtask : cmp_ctl
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    // Every strobe is set once per falling edge, so back-to-back pulses never glitch.
    task automatic drive(input logic w, input logic r, input logic q, input logic d);
        i_reg_write = w;
        i_reg_read = r;
        i_conv_request = q;
        i_conv_done = d;
        @(negedge i_clock);
    endtask : drive
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        i_reg_pointer = p;
        i_reg_wdata = d;
        drive(1'b1, 1'b0, 1'b0, 1'b0);
    endtask : wr
    task automatic rd(input logic [7:0] p, input logic [7:0] e);
        rd_q.push_back(e);
        i_reg_pointer = p;
        drive(1'b0, 1'b1, 1'b0, 1'b0);
    endtask : rd
    // Bounded wait for the channel to go idle; running out ends the run.
    task automatic wait_idle;
        for (int k = 0; k < 20; k++) begin
            if (o_conv_busy === 1'b0) return;
            drive(1'b0, 1'b0, 1'b0, 1'b0);
        end
        n_mismatch++;
        wrap_up();
    endtask : wait_idle
    // Programs the setup, starts one conversion and finishes it with the given data.
    task automatic convert(input logic [7:0] st, input logic [23:0] data, input logic hold);
        ctl_q.push_back({4'h1 << st[6:5], st[4] & st[6], st[1], st[0]});
        wr(vtc_pkg::PTR_SETUP, st);
        drive(1'b0, 1'b0, 1'b1, 1'b0);
        drive(1'b0, 1'b0, 1'b0, 1'b0);
        drive(1'b0, 1'b0, 1'b0, 1'b0);
        i_conv_data = data;
        i_result_read_active = hold;
        drive(1'b0, 1'b0, 1'b0, 1'b1);
        wait_idle();
        chk("lost", 24'(hold), 24'(o_result_lost));
        // The ready flag rises one cycle after the capture pulse, so let that edge pass.
        drive(1'b0, 1'b0, 1'b0, 1'b0);
    endtask : convert
    // Monitor: compares each read answer and each conversion start after the edge settles.
    always @(posedge i_clock) begin
        mon_rd = i_reg_read && !i_rst;
        #5;
        if (mon_rd) begin
            rd_exp = rd_q.pop_front();
            cmp_rd(rd_exp);
        end
        if (o_conv_go === 1'b1) begin
            ctl_exp = ctl_q.pop_front();
            cmp_ctl(ctl_exp);
        end
    end
    // Main sequence: reset values, masking, refusal, every input code, frozen result.
    initial begin
        repeat (6) @(negedge i_clock);
        i_rst = 1'b0;
        rd(vtc_pkg::PTR_SETUP, vtc_pkg::SETUP_RESET);
        for (int p = 4; p < 7; p++) rd(8'(p), 8'h00);
        wr(vtc_pkg::PTR_SETUP, 8'hff);
        rd(vtc_pkg::PTR_SETUP, 8'hf3);
        wr(8'h09, 8'h00);
        rd(8'h09, vtc_pkg::READ_NONE);
        rd(vtc_pkg::PTR_SETUP, 8'hf3);
        // With the channel disabled a request must not start anything.
        wr(vtc_pkg::PTR_SETUP, 8'h71);
        drive(1'b0, 1'b0, 1'b1, 1'b0);
        drive(1'b0, 1'b0, 1'b0, 1'b0);
        chk("busy", 24'h0, 24'(o_conv_busy));
        for (int k = 0; k < 8; k++) begin
            // The external reference is never asked for with the internal sensor selected.
            s = {1'b1, k[1:0], k[2] & (k[1:0] != 2'b00), 2'b00, 2'($random(seed))};
            res = 24'($random(seed));
            convert(s, res, 1'b0);
            chk("ready", 24'h1, 24'(o_data_ready));
            i_result_read_active = 1'b1;
            rd(vtc_pkg::PTR_RESULT_HI, res[23:16]);
            rd(vtc_pkg::PTR_RESULT_MID, res[15:8]);
            rd(vtc_pkg::PTR_RESULT_LO, res[7:0]);
            i_result_read_active = 1'b0;
            drive(1'b0, 1'b0, 1'b0, 1'b0);
            chk("ready", 24'h0, 24'(o_data_ready));
        end
        // A result finishing under a read is dropped and the old one stays.
        convert(8'h81, ~res, 1'b1);
        i_result_read_active = 1'b0;
        chk("ready", 24'h0, 24'(o_data_ready));
        rd(vtc_pkg::PTR_RESULT_HI, res[23:16]);
        drive(1'b0, 1'b0, 1'b0, 1'b0);
        drive(1'b0, 1'b0, 1'b0, 1'b0);
        wrap_up();
    end
endmodule : testbench
